/* File: fsf_status_flags.sv */
`timescale 1ns/100ps
// How it works
// - Stack fault: flag one shows overflow direction
// - Inexact result: flag one shows round-up
// - Examine: sign to flag one, class elsewhere
// - Remainder: flag two marks incomplete reduction
// - Completed remainder: quotient bits into flags
// - Trig out of range sets flag two
// - Compare encodes result, clears flag one
// - Flag-setting compare touches flag one only
// - Environment load and restore write flags
// - Six sticky exception flags, low bits
// - Unmasked set flag raises error summary
// - Masked exceptions set flag, not summary
// - Exceptions stay until clear, init, save, load, restore
// - Top bit mirrors error summary, read-only
// - Stack fault set, never cleared by invalid
// - Stack fault cleared by init, clear, save
// - Sixteen-bit word follows completed operations
// - Stack pointer sits in bits eleven to thirteen
// - Control mask bits block matching exceptions
module fsf_status_flags
  import fsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Completion from the execution pipe
  input wire logic done_valid,
  input wire fsf_complete_type done,
  // Memory image for load and restore
  input wire logic [FSF_WORD_W-1:0] image_word,
  // Control word exception masks
  input wire logic [FSF_EXC_N-1:0] exc_mask,
  // Status word and handler request
  output logic [FSF_WORD_W-1:0] fpu_state_word,
  output logic error_summary,
  output logic stack_fault
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic cond_flag_zero;
  logic cond_flag_one;
  logic cond_flag_two;
  logic cond_flag_three;
  logic [FSF_EXC_N-1:0] exc_flags;
  logic [2:0] top_ptr;
  logic next_c0;
  logic next_c1;
  logic next_c2;
  logic next_c3;

  // Ops that reset flags to their initial state
  function automatic logic is_reinit(input fsf_op_type op);
    return (op == FSF_OP_UNIT_INITIALISE) || (op == FSF_OP_SAVE_STATE);
  endfunction

  // Ops that overwrite the word from memory
  function automatic logic is_reload(input fsf_op_type op);
    return (op == FSF_OP_LOAD_ENVIRONMENT) || (op == FSF_OP_RESTORE_STATE);
  endfunction

  // ----------------------------------------------------------------
  // Condition flag next values
  // ----------------------------------------------------------------
  // Undefined cases hold the old value; software must not rely on it
  always_comb begin
    next_c0 = cond_flag_zero;
    next_c1 = cond_flag_one;
    next_c2 = cond_flag_two;
    next_c3 = cond_flag_three;
    unique case (done.op)
      FSF_OP_ARITH, FSF_OP_LOAD_MOVE: begin
        next_c1 = done.round_up;
      end
      FSF_OP_TRIG: begin
        next_c2 = done.out_of_range;
        if (!done.out_of_range) begin
          next_c1 = done.round_up;
        end
      end
      FSF_OP_COMPARE: begin
        {next_c3, next_c2, next_c0} = done.cmp_code;
        next_c1 = 1'b0;
      end
      FSF_OP_COMPARE_SET_FLAGS: begin
        next_c1 = cond_flag_one;
      end
      FSF_OP_EXAMINE: begin
        next_c1 = done.sign;
        {next_c3, next_c2, next_c0} = done.class_code;
      end
      FSF_OP_PARTIAL_REMAINDER: begin
        next_c2 = done.reduce_incomplete;
        if (!done.reduce_incomplete) begin
          {next_c0, next_c3, next_c1} = done.quotient;
        end
      end
      FSF_OP_LOAD_ENVIRONMENT, FSF_OP_RESTORE_STATE: begin
        next_c0 = image_word[FSF_POS_C0];
        next_c1 = image_word[FSF_POS_C1];
        next_c2 = image_word[FSF_POS_C2];
        next_c3 = image_word[FSF_POS_C3];
      end
      FSF_OP_UNIT_INITIALISE, FSF_OP_SAVE_STATE: begin
        {next_c3, next_c2, next_c1, next_c0} = FSF_COND_RESET;
      end
      default: begin
        next_c0 = cond_flag_zero;
      end
    endcase
    // A stack fault overrides flag one with its direction
    if (done.stack_fault && !is_reload(done.op) && !is_reinit(done.op)) begin
      next_c1 = done.stack_overflow;
    end
  end

  // ----------------------------------------------------------------
  // Condition flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {cond_flag_three, cond_flag_two, cond_flag_one, cond_flag_zero} <= FSF_COND_RESET;
    end else if (done_valid) begin
      cond_flag_zero <= next_c0;
      cond_flag_one <= next_c1;
      cond_flag_two <= next_c2;
      cond_flag_three <= next_c3;
    end
  end

  // ----------------------------------------------------------------
  // Sticky exception flags
  // ----------------------------------------------------------------
  // Flags set even when masked; only the summary honours the mask
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exc_flags <= FSF_EXC_RESET;
    end else if (done_valid) begin
      if (is_reload(done.op)) begin
        exc_flags <= image_word[FSF_EXC_N-1:0];
      end else if (is_reinit(done.op) || done.op == FSF_OP_CLEAR_EXCEPTIONS) begin
        exc_flags <= FSF_EXC_RESET;
      end else begin
        exc_flags <= exc_flags | done.exc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack fault flag
  // ----------------------------------------------------------------
  // Invalid operand without stack fault leaves this bit alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stack_fault <= 1'b0;
    end else if (done_valid) begin
      if (is_reload(done.op)) begin
        stack_fault <= image_word[FSF_POS_SF];
      end else if (is_reinit(done.op) || done.op == FSF_OP_CLEAR_EXCEPTIONS) begin
        stack_fault <= 1'b0;
      end else if (done.stack_fault) begin
        stack_fault <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer field
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      top_ptr <= FSF_TOP_RESET;
    end else if (done_valid) begin
      if (is_reload(done.op)) begin
        top_ptr <= image_word[FSF_POS_TOP +: 3];
      end else if (is_reinit(done.op)) begin
        top_ptr <= FSF_TOP_RESET;
      end else begin
        top_ptr <= done.top;
      end
    end
  end

  // ----------------------------------------------------------------
  // Summary and word assembly
  // ----------------------------------------------------------------
  // Summary is derived, so it can never disagree with flags and masks
  assign error_summary = |(exc_flags & ~exc_mask);

  always_comb begin
    fpu_state_word = '0;
    fpu_state_word[FSF_EXC_N-1:0] = exc_flags;
    fpu_state_word[FSF_POS_SF] = stack_fault;
    fpu_state_word[FSF_POS_ES] = error_summary;
    fpu_state_word[FSF_POS_C0] = cond_flag_zero;
    fpu_state_word[FSF_POS_C1] = cond_flag_one;
    fpu_state_word[FSF_POS_C2] = cond_flag_two;
    fpu_state_word[FSF_POS_TOP +: 3] = top_ptr;
    fpu_state_word[FSF_POS_C3] = cond_flag_three;
    fpu_state_word[FSF_POS_BUSY_COPY] = error_summary;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_overflow_dir;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && done.stack_fault && done.op == FSF_OP_ARITH)
      |=> (cond_flag_one == $past(done.stack_overflow)) && stack_fault;
  endproperty
  a_overflow_dir: assert property (p_overflow_dir) else $error("C1 overflow direction wrong");

  property p_round_up;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && !done.stack_fault && done.op == FSF_OP_ARITH)
      |=> cond_flag_one == $past(done.round_up);
  endproperty
  a_round_up: assert property (p_round_up) else $error("round-up flag wrong");

  property p_remainder;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && !done.stack_fault && done.op == FSF_OP_PARTIAL_REMAINDER
      && !done.reduce_incomplete)
      |=> !cond_flag_two && {cond_flag_zero, cond_flag_three, cond_flag_one} == $past(done.quotient);
  endproperty
  a_remainder: assert property (p_remainder) else $error("quotient bits wrong");

  property p_trig_range;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && done.op == FSF_OP_TRIG && done.out_of_range) |=> cond_flag_two;
  endproperty
  a_trig_range: assert property (p_trig_range) else $error("range flag not set");

  property p_compare_clear;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && done.op == FSF_OP_COMPARE && !done.stack_fault) |=> !cond_flag_one;
  endproperty
  a_compare_clear: assert property (p_compare_clear) else $error("compare left C1 set");

  property p_sticky;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && done.op == FSF_OP_ARITH) |=> ((exc_flags & $past(exc_flags)) == $past(exc_flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("exception flag lost");

  property p_summary;
    @(posedge mclk) disable iff (!nrst)
    error_summary == |(fpu_state_word[FSF_EXC_N-1:0] & ~exc_mask);
  endproperty
  a_summary: assert property (p_summary) else $error("summary disagrees with flags");

  property p_mirror;
    @(posedge mclk) disable iff (!nrst)
    fpu_state_word[FSF_POS_BUSY_COPY] == fpu_state_word[FSF_POS_ES];
  endproperty
  a_mirror: assert property (p_mirror) else $error("bit 15 not mirroring summary");

  property p_init_clear;
    @(posedge mclk) disable iff (!nrst)
    (done_valid && done.op == FSF_OP_UNIT_INITIALISE)
      |=> fpu_state_word == '0;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("initialise left bits set");

  property p_sf_hold;
    @(posedge mclk) disable iff (!nrst)
    (stack_fault && done_valid && done.op == FSF_OP_ARITH) |=> stack_fault;
  endproperty
  a_sf_hold: assert property (p_sf_hold) else $error("stack fault cleared");

endmodule // fsf_status_flags

/* File: fsf_pkg.sv */
package fsf_pkg;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned FSF_WORD_W = 16;
  localparam int unsigned FSF_EXC_N = 6;
  localparam int unsigned FSF_POS_INV = 0;
  localparam int unsigned FSF_POS_SUB = 1;
  localparam int unsigned FSF_POS_DIV = 2;
  localparam int unsigned FSF_POS_OVF = 3;
  localparam int unsigned FSF_POS_UNF = 4;
  localparam int unsigned FSF_POS_INX = 5;
  localparam int unsigned FSF_POS_SF = 6;
  localparam int unsigned FSF_POS_ES = 7;
  localparam int unsigned FSF_POS_C0 = 8;
  localparam int unsigned FSF_POS_C1 = 9;
  localparam int unsigned FSF_POS_C2 = 10;
  localparam int unsigned FSF_POS_TOP = 11;
  localparam int unsigned FSF_POS_C3 = 14;
  localparam int unsigned FSF_POS_BUSY_COPY = 15;

  // ----------------------------------------------------------------
  // Reset and initialise values
  // ----------------------------------------------------------------
  localparam logic [3:0] FSF_COND_RESET = 4'h0;
  localparam logic [5:0] FSF_EXC_RESET = 6'h00;
  localparam logic [2:0] FSF_TOP_RESET = 3'h0;
  localparam logic [5:0] FSF_MASK_RESET = 6'h3f;

  // ----------------------------------------------------------------
  // Operation classes as they complete
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FSF_OP_NONE,
    FSF_OP_ARITH,
    FSF_OP_TRIG,
    FSF_OP_COMPARE,
    FSF_OP_COMPARE_SET_FLAGS,
    FSF_OP_EXAMINE,
    FSF_OP_PARTIAL_REMAINDER,
    FSF_OP_LOAD_MOVE,
    FSF_OP_LOAD_ENVIRONMENT,
    FSF_OP_RESTORE_STATE,
    FSF_OP_CLEAR_EXCEPTIONS,
    FSF_OP_UNIT_INITIALISE,
    FSF_OP_SAVE_STATE,
    FSF_OP_CONTROL
  } fsf_op_type;

  // Completion record from the execution pipe
  typedef struct packed {
    fsf_op_type op;
    logic [5:0] exc;
    logic stack_fault;
    logic stack_overflow;
    logic round_up;
    logic sign;
    logic [2:0] class_code;
    logic [2:0] cmp_code;
    logic reduce_incomplete;
    logic [2:0] quotient;
    logic out_of_range;
    logic [2:0] top;
  } fsf_complete_type;

endpackage

/* File: fpu_status_flag_logic_test.sv */
`timescale 1ns/100ps
module fpu_status_flag_logic_test
  import fsf_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk;
  logic nrst;
  logic done_valid;
  fsf_complete_type done;
  logic [FSF_WORD_W-1:0] image_word;
  logic [FSF_EXC_N-1:0] exc_mask;
  logic [FSF_WORD_W-1:0] fpu_state_word;
  logic error_summary;
  logic stack_fault;
  fsf_complete_type rec;
  int num_errors;
  int total_checks;
  int k;

  fsf_status_flags dut (
    .mclk(mclk),
    .nrst(nrst),
    .done_valid(done_valid),
    .done(done),
    .image_word(image_word),
    .exc_mask(exc_mask),
    .fpu_state_word(fpu_state_word),
    .error_summary(error_summary),
    .stack_fault(stack_fault)
  );

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Whole run is about sixty cycles, so two thousand is ample
  initial begin
    #(25 * 2000);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Quiet record; stack pointer held at 3 so it never masks a flag slip
  function automatic fsf_complete_type base(input fsf_op_type op);
    base = '0;
    base.op = op;
    base.top = 3'h3;
  endfunction

  // Expected word from {c3,c2,c1,c0}; summary worked out from current masks
  function automatic logic [15:0] ew(input logic [3:0] c, input logic [2:0] t,
                                     input logic sf, input logic [5:0] x);
    logic es;
    es = |(x & ~exc_mask);
    ew = {es, c[3], t, c[2], c[1], c[0], es, sf, x};
  endfunction

  // One completion pulse; returns just after the edge that takes it
  task automatic issue(input logic [15:0] img);
    @(posedge mclk);
    done <= rec;
    image_word <= img;
    done_valid <= 1'b1;
    @(posedge mclk);
    done_valid <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    done_valid = 1'b0;
    done = '0;
    image_word = 16'h0000;
    exc_mask = 6'h3f;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    check(fpu_state_word, 16'h0000);
    @(posedge mclk);
    nrst <= 1'b1;
    // Masked inexact with round-up, then without
    rec = base(FSF_OP_ARITH); rec.exc = 6'h20; rec.round_up = 1'b1;
    issue(16'h0000);
    check(fpu_state_word, ew(4'h2, 3'h3, 1'b0, 6'h20));
    rec.round_up = 1'b0;
    issue(16'h0000);
    check(fpu_state_word, ew(4'h0, 3'h3, 1'b0, 6'h20));
    // Unmasking a set flag raises the summary and its mirror at once
    @(posedge mclk);
    exc_mask <= 6'h1f;
    #1;
    check({15'h0000, error_summary}, 16'h0001);
    check(fpu_state_word, ew(4'h0, 3'h3, 1'b0, 6'h20));
    @(posedge mclk);
    exc_mask <= 6'h3f;
    #1;
    check({15'h0000, error_summary}, 16'h0001 ^ 16'h0001);
    // Every compare outcome; flag one cleared even with round-up offered
    for (k = 0; k < 8; k++) begin
      rec = base(FSF_OP_COMPARE); rec.cmp_code = k[2:0]; rec.round_up = 1'b1;
      issue(16'h0000);
      check(fpu_state_word, ew({k[2], k[1], 1'b0, k[0]}, 3'h3, 1'b0, 6'h20));
    end
    // Flag-setting compare with overflow fault touches flag one only
    rec = base(FSF_OP_COMPARE_SET_FLAGS); rec.exc = 6'h01;
    rec.stack_fault = 1'b1; rec.stack_overflow = 1'b1;
    issue(16'h0000);
    check(fpu_state_word, ew(4'hf, 3'h3, 1'b1, 6'h21));
    check({15'h0000, stack_fault}, 16'h0001);
    // Underflow fault beats round-up; then a plain invalid keeps the fault
    rec = base(FSF_OP_ARITH); rec.exc = 6'h01; rec.round_up = 1'b1; rec.stack_fault = 1'b1;
    issue(16'h0000);
    check(fpu_state_word, ew(4'hd, 3'h3, 1'b1, 6'h21));
    rec = base(FSF_OP_ARITH); rec.exc = 6'h01;
    issue(16'h0000);
    check(fpu_state_word, ew(4'hd, 3'h3, 1'b1, 6'h21));
    // Examine: negative value, class {c3,c2,c0} = 011
    rec = base(FSF_OP_EXAMINE); rec.sign = 1'b1; rec.class_code = 3'h3;
    issue(16'h0000);
    check(fpu_state_word, ew(4'h7, 3'h3, 1'b1, 6'h21));
    // Partial remainder: incomplete, then two completed quotients
    rec = base(FSF_OP_PARTIAL_REMAINDER); rec.reduce_incomplete = 1'b1;
    issue(16'h0000);
    check({15'h0000, fpu_state_word[FSF_POS_C2]}, 16'h0001);
    rec = base(FSF_OP_PARTIAL_REMAINDER); rec.quotient = 3'h5;
    issue(16'h0000);
    check(fpu_state_word, ew(4'h3, 3'h3, 1'b1, 6'h21));
    rec.quotient = 3'h2;
    issue(16'h0000);
    check(fpu_state_word, ew(4'h8, 3'h3, 1'b1, 6'h21));
    // Trig source beyond range
    rec = base(FSF_OP_TRIG); rec.out_of_range = 1'b1;
    issue(16'h0000);
    check({15'h0000, fpu_state_word[FSF_POS_C2]}, 16'h0001);
    // Clearing drops the sticky flags and the fault
    rec = base(FSF_OP_CLEAR_EXCEPTIONS);
    issue(16'h0000);
    check(fpu_state_word & 16'h00ff, 16'h0000);
    check({15'h0000, stack_fault}, 16'h0000);
    // Reload from memory image; summary bits are never loaded
    rec = base(FSF_OP_LOAD_ENVIRONMENT);
    issue(16'h5a3f);
    check(fpu_state_word, 16'h5a3f);
    rec = base(FSF_OP_RESTORE_STATE);
    issue(16'hc5c0);
    check(fpu_state_word, 16'h4540);
    // Save and initialise both wipe flags, fault and stack pointer
    for (k = 0; k < 2; k++) begin
      rec = base(FSF_OP_ARITH); rec.exc = 6'h05; rec.round_up = 1'b1; rec.stack_fault = 1'b1;
      issue(16'h0000);
      rec = base(k == 0 ? FSF_OP_SAVE_STATE : FSF_OP_UNIT_INITIALISE);
      issue(16'h0000);
      check(fpu_state_word, 16'h0000);
    end
    end_sim();
  end
endmodule // fpu_status_flag_logic_test
